// ---- pkg/drive_io_pkg.sv ----
package drive_io_pkg;

    // Sizes
    localparam int NUM_INPUTS = 5;
    localparam int DATA_W     = 32;
    localparam int ADDR_W     = 8;
    localparam int CFG_W      = 16;
    localparam int SW_W       = 4;
    localparam int PIN_W      = 2 * SW_W + NUM_INPUTS + 1;

    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int US_NS         = 1000;
    localparam int TICK_CYCLES   = US_NS / CLK_PERIOD_NS;
    localparam int TICK_W        = $clog2(TICK_CYCLES);

    // Debounce time limits, microseconds
    localparam logic [15:0] FILTER_MIN_US     = 16'h0032;
    localparam logic [15:0] FILTER_MAX_US     = 16'hea60;
    localparam logic [15:0] FILTER_DEFAULT_US = 16'h03e8;

    // Role codes, as bit positions of the role word
    localparam int ROLE_HOME_BIT  = 0;
    localparam int ROLE_POS_BIT   = 1;
    localparam int ROLE_NEG_BIT   = 2;
    localparam int ROLE_ESTOP_BIT = 3;
    localparam int ROLE_USER_BIT  = 4;
    localparam logic [15:0] ROLE_MAX = 16'h8000;
    localparam logic [15:0] ROLE_RST [NUM_INPUTS] =
        '{16'h0020, 16'h0001, 16'h0002, 16'h0004, 16'h0010};
    localparam logic [15:0] POLARITY_RST = 16'h0000;

    // Role status word layout
    localparam int ST_NEG_BIT   = 0;
    localparam int ST_POS_BIT   = 1;
    localparam int ST_HOME_BIT  = 2;
    localparam int ST_ESTOP_BIT = 16;
    localparam int ST_USER_LSB  = 17;

    // Alias
    localparam logic [15:0] ALIAS_SEL_PARAM     = 16'h0001;
    localparam logic [15:0] SII_ALIAS_ADDR      = 16'h0004;
    localparam logic [2:0]  ALIAS_SETTLE_CYCLES = 3'h4;

    // Register map
    localparam logic [7:0] ADDR_ROLE_BASE   = 8'h00;
    localparam logic [7:0] ADDR_FILT_BASE   = 8'h08;
    localparam logic [7:0] ADDR_POLARITY    = 8'h10;
    localparam logic [7:0] ADDR_LEVEL       = 8'h11;
    localparam logic [7:0] ADDR_ROLE_STATUS = 8'h12;
    localparam logic [7:0] ADDR_ALIAS_SEL   = 8'h13;
    localparam logic [7:0] ADDR_ALIAS_PARAM = 8'h14;
    localparam logic [7:0] ADDR_ALIAS_LIVE  = 8'h15;

endpackage : drive_io_pkg

// ---- pkg/filter_if.sv ----
`timescale 1ns/1ps
interface filter_if;
    logic        tick_us;
    logic        raw;
    logic [15:0] time_us;
    logic        level;

    modport ctrl (output tick_us, output raw, output time_us, input level);
    modport filt (input tick_us, input raw, input time_us, output level);
endinterface : filter_if

// ---- rtl/drive_input_alias.sv ----
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - Switch alias: high switch upper digit
// - Both switches zero: use stored word
// - Parameter method takes alias parameter value
// - Alias latched once after each reset release
// - Role codes: home, limits, stop, user
// - Per-input filter time, 50 to 60000us
// - Polarity bit per input, zero active low
// - Read-only filtered level word
// - Status: neg, pos, home, stop bits
// - Bits 17-21 show user-defined input levels
// - Drive four network status indicators
// - Power-up default roles per input
module drive_input_alias
(
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 arst_n,
    // Register port
    input  wire logic [7:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [31:0]          reg_rdata,
    // Digital input pins
    input  wire logic                 input_line_one,
    input  wire logic                 input_line_two,
    input  wire logic                 input_line_three,
    input  wire logic                 input_line_four,
    input  wire logic                 input_line_five_pos,
    input  wire logic                 input_line_five_neg,
    // Rotary switches
    input  wire logic [3:0]           alias_high_digit_switch,
    input  wire logic [3:0]           alias_low_digit_switch,
    // Stored alias sources
    output logic      [15:0]          sii_read_addr,
    input  wire logic [15:0]          sii_alias_word,
    input  wire logic [15:0]          stored_alias_select,
    input  wire logic [15:0]          stored_alias_param,
    // Alias result
    output logic      [15:0]          station_alias,
    output logic                      station_alias_valid,
    // Input roles toward motion logic
    output logic      [31:0]          role_status,
    // Indicator requests
    input  wire logic                 link_in_active,
    input  wire logic                 link_out_active,
    input  wire logic                 run_request,
    input  wire logic                 error_request,
    // Indicators
    output logic                      inbound_link_indicator,
    output logic                      outbound_link_indicator,
    output logic                      run_indicator,
    output logic                      error_indicator
);

    localparam int N = drive_io_pkg::NUM_INPUTS;

    // Reset release synchroniser
    logic rst_meta_reg;
    logic rst_n_reg;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // Pin synchroniser, change taken when stages two and three agree
    logic [drive_io_pkg::PIN_W-1:0] pin_raw;
    logic [drive_io_pkg::PIN_W-1:0] pin_s1_reg;
    logic [drive_io_pkg::PIN_W-1:0] pin_s2_reg;
    logic [drive_io_pkg::PIN_W-1:0] pin_s3_reg;
    logic [drive_io_pkg::PIN_W-1:0] pin_reg;
    logic [drive_io_pkg::PIN_W-1:0] pin_agree;

    assign pin_raw = {alias_high_digit_switch, alias_low_digit_switch,
                      input_line_five_neg, input_line_five_pos,
                      input_line_four, input_line_three,
                      input_line_two, input_line_one};
    assign pin_agree = ~(pin_s2_reg ^ pin_s3_reg);

    always_ff @(posedge ref_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            pin_s3_reg <= '0;
            pin_reg    <= '0;
        end
        else
        begin
            pin_s1_reg <= pin_raw;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            pin_reg    <= (pin_s2_reg & pin_agree) | (pin_reg & ~pin_agree);
        end
    end

    // Differential fifth input reads high when plus is above minus
    logic [N-1:0] in_raw;
    logic [3:0]   sw_high;
    logic [3:0]   sw_low;

    assign in_raw  = {pin_reg[4] & ~pin_reg[5], pin_reg[3:0]};
    assign sw_low  = pin_reg[9:6];
    assign sw_high = pin_reg[13:10];

    // Microsecond tick
    logic [drive_io_pkg::TICK_W-1:0] tick_cnt_reg;
    logic                            tick_us_reg;

    always_ff @(posedge ref_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            tick_cnt_reg <= '0;
            tick_us_reg  <= 1'b0;
        end
        else if (tick_cnt_reg ==
                 drive_io_pkg::TICK_W'(drive_io_pkg::TICK_CYCLES - 1))
        begin
            tick_cnt_reg <= '0;
            tick_us_reg  <= 1'b1;
        end
        else
        begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
            tick_us_reg  <= 1'b0;
        end
    end

    // Per-input configuration and filtering
    logic [15:0]  role_reg [N];
    logic [15:0]  filt_reg [N];
    logic [N-1:0] level;
    logic [15:0]  polarity_reg;

    generate
        for (genvar i = 0; i < N; i++)
        begin : g_in
            filter_if fch ();

            assign fch.tick_us = tick_us_reg;
            assign fch.raw     = in_raw[i];
            assign fch.time_us = filt_reg[i];
            assign level[i]    = fch.level;

            input_debounce u_deb
            (
                .ref_clk (ref_clk),
                .rst_n   (rst_n_reg),
                .f       (fch.filt)
            );

            always_ff @(posedge ref_clk or negedge rst_n_reg)
            begin
                if (!rst_n_reg)
                begin
                    role_reg[i] <= drive_io_pkg::ROLE_RST[i];
                end
                else if (reg_wr && reg_addr ==
                         drive_io_pkg::ADDR_ROLE_BASE + 8'(i) &&
                         reg_wdata[15:0] <= drive_io_pkg::ROLE_MAX)
                begin
                    role_reg[i] <= reg_wdata[15:0];
                end
            end

            always_ff @(posedge ref_clk or negedge rst_n_reg)
            begin
                if (!rst_n_reg)
                begin
                    filt_reg[i] <= drive_io_pkg::FILTER_DEFAULT_US;
                end
                else if (reg_wr && reg_addr ==
                         drive_io_pkg::ADDR_FILT_BASE + 8'(i) &&
                         reg_wdata[15:0] >= drive_io_pkg::FILTER_MIN_US &&
                         reg_wdata[15:0] <= drive_io_pkg::FILTER_MAX_US)
                begin
                    filt_reg[i] <= reg_wdata[15:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            polarity_reg <= drive_io_pkg::POLARITY_RST;
        end
        else if (reg_wr && reg_addr == drive_io_pkg::ADDR_POLARITY)
        begin
            polarity_reg <= reg_wdata[15:0];
        end
    end

    // Active state after polarity: zero bit means active low
    logic [N-1:0] active;

    assign active = ~(level ^ polarity_reg[N-1:0]);

    logic [31:0] status_next;
    logic [31:0] status_reg;

    always_comb
    begin
        status_next = '0;
        for (int k = 0; k < N; k++)
        begin
            if (role_reg[k][drive_io_pkg::ROLE_NEG_BIT] && active[k])
            begin
                status_next[drive_io_pkg::ST_NEG_BIT] = 1'b1;
            end
            if (role_reg[k][drive_io_pkg::ROLE_POS_BIT] && active[k])
            begin
                status_next[drive_io_pkg::ST_POS_BIT] = 1'b1;
            end
            if (role_reg[k][drive_io_pkg::ROLE_HOME_BIT] && active[k])
            begin
                status_next[drive_io_pkg::ST_HOME_BIT] = 1'b1;
            end
            if (role_reg[k][drive_io_pkg::ROLE_ESTOP_BIT] && active[k])
            begin
                status_next[drive_io_pkg::ST_ESTOP_BIT] = 1'b1;
            end
            if (role_reg[k][drive_io_pkg::ROLE_USER_BIT])
            begin
                status_next[drive_io_pkg::ST_USER_LSB + k] = level[k];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            status_reg <= '0;
        end
        else
        begin
            status_reg <= status_next;
        end
    end

    assign role_status = status_reg;

    // Alias configuration registers, read back only; alias_pick uses the stored_alias_select input
    logic [15:0] alias_sel_reg;
    logic [15:0] alias_param_reg;

    always_ff @(posedge ref_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            alias_sel_reg   <= '0;
            alias_param_reg <= '0;
        end
        else if (reg_wr && reg_addr == drive_io_pkg::ADDR_ALIAS_SEL)
        begin
            alias_sel_reg <= reg_wdata[15:0];
        end
        else if (reg_wr && reg_addr == drive_io_pkg::ADDR_ALIAS_PARAM)
        begin
            alias_param_reg <= reg_wdata[15:0];
        end
    end

    // stored word is fetched from its fixed address
    assign sii_read_addr = drive_io_pkg::SII_ALIAS_ADDR;

    // Alias source choice
    logic [15:0] alias_pick;

    always_comb
    begin
        if (stored_alias_select == drive_io_pkg::ALIAS_SEL_PARAM)
        begin
            alias_pick = stored_alias_param;
        end
        else if ({sw_high, sw_low} != 8'h00)
        begin
            alias_pick = {8'h00, sw_high, sw_low};
        end
        else
        begin
            alias_pick = sii_alias_word;
        end
    end

    // one capture after reset release, once switches settled
    logic [2:0]  settle_reg;
    logic        alias_valid_reg;
    logic [15:0] alias_reg;

    always_ff @(posedge ref_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            settle_reg      <= '0;
            alias_valid_reg <= 1'b0;
            alias_reg       <= '0;
        end
        else if (!alias_valid_reg)
        begin
            if (settle_reg == drive_io_pkg::ALIAS_SETTLE_CYCLES)
            begin
                alias_valid_reg <= 1'b1;
                alias_reg       <= alias_pick;
            end
            else
            begin
                settle_reg <= settle_reg + 3'h1;
            end
        end
    end

    assign station_alias       = alias_reg;
    assign station_alias_valid = alias_valid_reg;

    always_ff @(posedge ref_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            inbound_link_indicator  <= 1'b0;
            outbound_link_indicator <= 1'b0;
            run_indicator           <= 1'b0;
            error_indicator         <= 1'b0;
        end
        else
        begin
            inbound_link_indicator  <= link_in_active;
            outbound_link_indicator <= link_out_active;
            run_indicator           <= run_request;
            error_indicator         <= error_request;
        end
    end

    // Read mux, unmapped reads return zero
    logic [31:0] rd_mux;

    always_comb
    begin
        rd_mux = '0;
        for (int k = 0; k < N; k++)
        begin
            if (reg_addr == drive_io_pkg::ADDR_ROLE_BASE + 8'(k))
            begin
                rd_mux = {16'h0000, role_reg[k]};
            end
            if (reg_addr == drive_io_pkg::ADDR_FILT_BASE + 8'(k))
            begin
                rd_mux = {16'h0000, filt_reg[k]};
            end
        end
        case (reg_addr)
            drive_io_pkg::ADDR_POLARITY:
                rd_mux = {16'h0000, polarity_reg};
            drive_io_pkg::ADDR_LEVEL:
                rd_mux = {27'h0000000, level};
            drive_io_pkg::ADDR_ROLE_STATUS:
                rd_mux = status_reg;
            drive_io_pkg::ADDR_ALIAS_SEL:
                rd_mux = {16'h0000, alias_sel_reg};
            drive_io_pkg::ADDR_ALIAS_PARAM:
                rd_mux = {16'h0000, alias_param_reg};
            drive_io_pkg::ADDR_ALIAS_LIVE:
                rd_mux = {16'h0000, alias_reg};
            default:
                rd_mux = rd_mux;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            reg_rdata <= '0;
        end
        else if (reg_rd)
        begin
            reg_rdata <= rd_mux;
        end
        else
        begin
            reg_rdata <= '0;
        end
    end

endmodule : drive_input_alias

// ---- rtl/input_debounce.sv ----
`timescale 1ns/1ps
module input_debounce
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Filter channel
    filter_if.filt    f
);

    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic        level_reg;
    logic        level_next;

    always_comb
    begin
        cnt_next   = cnt_reg;
        level_next = level_reg;
        if (f.raw == level_reg)
        begin
            cnt_next = '0;
        end
        else if (f.tick_us)
        begin
            if (cnt_reg + 16'h0001 >= f.time_us)
            begin
                level_next = f.raw;
                cnt_next   = '0;
            end
            else
            begin
                cnt_next = cnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_reg   <= '0;
            level_reg <= 1'b0;
        end
        else
        begin
            cnt_reg   <= cnt_next;
            level_reg <= level_next;
        end
    end

    assign f.level = level_reg;

endmodule : input_debounce

// ---- test/drive_input_monitor.sv ----
`timescale 1ns/1ps
module drive_input_monitor
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    // Register port
    input  wire logic        reg_rd,
    input  wire logic [31:0] reg_rdata,
    // Alias sources and result
    input  wire logic [3:0]  alias_high_digit_switch,
    input  wire logic [3:0]  alias_low_digit_switch,
    input  wire logic [15:0] sii_read_addr,
    input  wire logic [15:0] sii_alias_word,
    input  wire logic [15:0] stored_alias_select,
    input  wire logic [15:0] stored_alias_param,
    input  wire logic [15:0] station_alias,
    input  wire logic        station_alias_valid,
    input  wire logic [31:0] role_status,
    // Indicators
    input  wire logic        link_in_active,
    input  wire logic        link_out_active,
    input  wire logic        run_request,
    input  wire logic        error_request,
    input  wire logic        inbound_link_indicator,
    input  wire logic        outbound_link_indicator,
    input  wire logic        run_indicator,
    input  wire logic        error_indicator
);
    logic [3:0] up_cnt;
    logic       sw_zero;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    assign sw_zero = {alias_high_digit_switch, alias_low_digit_switch} == 8'h00;

    // Cycles since reset release, saturating
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            up_cnt <= 4'h0;
        else if (up_cnt != 4'hf)
            up_cnt <= up_cnt + 4'h1;
    end

    a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its slot");
    a_sii_addr_fixed: assert property (sii_read_addr == 16'h0004)
        else $error("stored alias address wrong");
    a_switch_alias: assert property ($rose(station_alias_valid) &&
        stored_alias_select != 16'h0001 && !sw_zero |->
        station_alias == {8'h00, alias_high_digit_switch, alias_low_digit_switch})
        else $error("switch alias wrong");
    a_stored_alias: assert property ($rose(station_alias_valid) &&
        stored_alias_select != 16'h0001 && sw_zero |->
        station_alias == sii_alias_word)
        else $error("stored alias wrong");
    a_param_alias: assert property ($rose(station_alias_valid) &&
        stored_alias_select == 16'h0001 |-> station_alias == stored_alias_param)
        else $error("parameter alias wrong");
    a_alias_held: assert property (station_alias_valid |=>
        station_alias_valid && $stable(station_alias))
        else $error("alias changed");
    a_valid_not_early: assert property (up_cnt <= 4'h3 |-> !station_alias_valid)
        else $error("alias valid too early");
    a_valid_in_time: assert property (up_cnt == 4'hc |-> station_alias_valid)
        else $error("alias not captured");
    a_led_follow: assert property (up_cnt >= 4'h6 |->
        {inbound_link_indicator, outbound_link_indicator, run_indicator,
         error_indicator} == $past({link_in_active, link_out_active,
         run_request, error_request}))
        else $error("indicator mismatch");

    c_read: cover property (reg_rd ##1 reg_rdata != 32'h0);
    c_alias: cover property ($rose(station_alias_valid));
    c_estop: cover property (role_status[16]);
    c_user: cover property (role_status[21:17] != 5'h00);
endmodule : drive_input_monitor

bind drive_input_alias drive_input_monitor mon_u (
    .ref_clk(ref_clk), .arst_n(arst_n), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .alias_high_digit_switch(alias_high_digit_switch),
    .alias_low_digit_switch(alias_low_digit_switch),
    .sii_read_addr(sii_read_addr), .sii_alias_word(sii_alias_word),
    .stored_alias_select(stored_alias_select),
    .stored_alias_param(stored_alias_param),
    .station_alias(station_alias), .station_alias_valid(station_alias_valid),
    .role_status(role_status), .link_in_active(link_in_active),
    .link_out_active(link_out_active), .run_request(run_request),
    .error_request(error_request),
    .inbound_link_indicator(inbound_link_indicator),
    .outbound_link_indicator(outbound_link_indicator),
    .run_indicator(run_indicator), .error_indicator(error_indicator));

// ---- test/input_line_driver.sv ----
`timescale 1ns/1ps
module input_line_driver
(
    // Requested input levels
    input  wire logic [4:0] level_req,
    // Input pins
    output logic            input_line_one,
    output logic            input_line_two,
    output logic            input_line_three,
    output logic            input_line_four,
    output logic            input_line_five_pos,
    output logic            input_line_five_neg
);
    assign input_line_one      = level_req[0];
    assign input_line_two      = level_req[1];
    assign input_line_three    = level_req[2];
    assign input_line_four     = level_req[3];
    // Pair driven in opposite phase
    assign input_line_five_pos = level_req[4];
    assign input_line_five_neg = ~level_req[4];
endmodule : input_line_driver

// ---- test/tb_drive_input_and_alias_logic.sv ----
`timescale 1ns/1ps
module tb_drive_input_and_alias_logic;
    logic        ref_clk;
    logic        arst_n;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic [4:0]  level_req;
    logic        in1, in2, in3, in4, in5p, in5n, alias_valid;
    logic [3:0]  sw_hi, sw_lo;
    logic [15:0] sii_addr, sii_word, alias_sel, alias_param, station_alias;
    logic [31:0] role_status;
    logic [3:0]  led_req, led_out;
    logic [31:0] seed = 32'h3633;
    logic [31:0] led_seed = 32'h3633;
    logic [15:0] roles [5];
    logic [15:0] rst_roles [5] = '{16'h20, 16'h1, 16'h2, 16'h4, 16'h10};
    logic [15:0] ft_w [4] = '{16'h0031, 16'h0032, 16'hea61, 16'hea60};
    logic [15:0] ft_e [4] = '{16'h03e8, 16'h0032, 16'h0032, 16'hea60};
    logic [15:0] exp_alias;
    logic [7:0]  sw_v;
    logic [4:0]  pol;
    int          k;
    int          n_errors;
    int          total_checks;

    input_line_driver drv_u (.level_req(level_req), .input_line_one(in1),
        .input_line_two(in2), .input_line_three(in3), .input_line_four(in4),
        .input_line_five_pos(in5p), .input_line_five_neg(in5n));

    drive_input_alias dut_u (.ref_clk(ref_clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .input_line_one(in1),
        .input_line_two(in2), .input_line_three(in3), .input_line_four(in4),
        .input_line_five_pos(in5p), .input_line_five_neg(in5n),
        .alias_high_digit_switch(sw_hi), .alias_low_digit_switch(sw_lo),
        .sii_read_addr(sii_addr), .sii_alias_word(sii_word),
        .stored_alias_select(alias_sel), .stored_alias_param(alias_param),
        .station_alias(station_alias), .station_alias_valid(alias_valid),
        .role_status(role_status), .link_in_active(led_req[0]),
        .link_out_active(led_req[1]), .run_request(led_req[2]),
        .error_request(led_req[3]), .inbound_link_indicator(led_out[0]),
        .outbound_link_indicator(led_out[1]), .run_indicator(led_out[2]),
        .error_indicator(led_out[3]));

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    function automatic logic [31:0] exp_status(input logic [4:0] lv,
                                               input logic [4:0] pl);
        logic [31:0] s;
        logic        act;
        s = 32'h0;
        for (int i = 0; i < 5; i++)
        begin
            act = lv[i] ~^ pl[i];
            s[0] = s[0] | (act & roles[i][2]);
            s[1] = s[1] | (act & roles[i][1]);
            s[2] = s[2] | (act & roles[i][0]);
            s[16] = s[16] | (act & roles[i][3]);
            s[17 + i] = lv[i] & roles[i][4];
        end
        return s;
    endfunction : exp_status

    task automatic conclude;
        $display("Checks %0d, errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk(reg_rdata, exp);
    endtask : rd_chk

    task automatic do_reset(input logic [15:0] sel, input logic [7:0] sw);
        @(posedge ref_clk);
        arst_n         <= 1'b0;
        alias_sel      <= sel;
        {sw_hi, sw_lo} <= sw;
        sii_word       <= seed[15:0];
        alias_param    <= seed[31:16];
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (20) @(posedge ref_clk);
    endtask : do_reset

    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Random indicator requests
    always @(posedge ref_clk)
    begin
        led_seed = xs(led_seed);
        led_req <= led_seed[3:0];
    end

    initial
    begin
        #600_000;
        n_errors++;
        conclude();
    end

    initial
    begin
        {arst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {level_req, sw_hi, sw_lo, sii_word, alias_sel, alias_param} = '0;
        for (int m = 0; m < 3; m++)
        begin
            seed = xs(seed);
            sw_v = (m == 0) ? 8'ha8 : (m == 1) ? 8'h00 : seed[7:0];
            exp_alias = (m == 0) ? 16'h00a8 : (m == 1) ? seed[15:0] : seed[31:16];
            do_reset((m == 2) ? 16'h0001 : 16'h0000, sw_v);
            chk({16'h0, station_alias}, {16'h0, exp_alias});
            chk({16'h0, sii_addr}, 32'h4);
            {sw_hi, sw_lo} <= ~sw_v;
            {sii_word, alias_param, alias_sel} <= ~{sii_word, alias_param, alias_sel};
            wr(8'h14, {16'h0, ~exp_alias});
            rd_chk(8'h14, {16'h0, ~exp_alias});
            wr(8'h13, 32'h1);
            rd_chk(8'h13, 32'h1);
            repeat (10) @(posedge ref_clk);
            rd_chk(8'h15, {16'h0, exp_alias});
            chk({31'h0, alias_valid}, 32'h1);
        end
        for (int i = 0; i < 5; i++)
        begin
            rd_chk(8'(i), {16'h0, rst_roles[i]});
            rd_chk(8'h08 + 8'(i), 32'h3e8);
        end
        rd_chk(8'h10, 32'h0);
        wr(8'h11, 32'h1f);
        rd_chk(8'h11, 32'h0);
        wr(8'h20, 32'h5a);
        rd_chk(8'h20, 32'h0);
        wr(8'h00, 32'h8001);
        rd_chk(8'h00, 32'h20);
        wr(8'h00, 32'h8000);
        rd_chk(8'h00, 32'h8000);
        seed = xs(seed);
        k = seed[7:0] % 5;
        for (int j = 0; j < 4; j++)
        begin
            wr(8'h08 + 8'(k), {16'h0, ft_w[j]});
            rd_chk(8'h08 + 8'(k), {16'h0, ft_e[j]});
        end
        for (int i = 0; i < 5; i++)
            wr(8'h08 + 8'(i), 32'h32);
        // Bounce restarts the count
        @(posedge ref_clk);
        level_req[k] <= 1'b1;
        repeat (5000) @(posedge ref_clk);
        level_req[k] <= 1'b0;
        repeat (10) @(posedge ref_clk);
        level_req[k] <= 1'b1;
        repeat (6000) @(posedge ref_clk);
        rd_chk(8'h11, 32'h0);
        repeat (400) @(posedge ref_clk);
        rd_chk(8'h11, 32'h1 << k);
        for (int it = 0; it < 6; it++)
        begin
            seed = xs(seed);
            pol = seed[4:0];
            wr(8'h10, {27'h0, pol});
            rd_chk(8'h10, {27'h0, pol});
            for (int i = 0; i < 5; i++)
            begin
                roles[i] = 16'h0001 << ((it + i) % 5);
                wr(8'(i), {16'h0, roles[i]});
            end
            @(posedge ref_clk);
            level_req <= seed[12:8];
            repeat (6500) @(posedge ref_clk);
            rd_chk(8'h11, {27'h0, seed[12:8]});
            rd_chk(8'h12, exp_status(seed[12:8], pol));
            chk(role_status, exp_status(seed[12:8], pol));
        end
        conclude();
    end
endmodule : tb_drive_input_and_alias_logic
